// *** core/fpd_pkg.sv ***
// fault pin, diagnostics and indicator constants and carrier types
// assumes one 40 MHz clock and a synchronous active-low reset in every user
// How it works
// - fault drives pin only when output, fault source
// - pin active while any unmasked summary flag low
// - format and polarity set driven levels
// - format allows 50 percent pwm when inactive
// - eight summary flags each have pin mask
// - diagnostic enable injects fault into its monitor
// - two-bit pattern field corrupts memory checksum
// - each frame reports previous frame command response
// - lock, clock source, mode, sequence running indicators
// - load otp bank 0, else bank 1, report
// - both banks failing drives checksum flag low
// - two-bit conversion counter wraps 3 to 0
// - conversion counter clears when disabled or idle mode
// - sent conversion count matches sent result
// - two-bit sequence counter, same wrap and clearing
// - results buffered while step results are read
// - step channel selector picks divided supply
// - combined flag low when unmasked detailed flag low
// - combined clear ignored while detailed flag set
package fpd_pkg;
    localparam int unsigned CLK_HZ       = 40_000_000;
    localparam int unsigned N_SUM        = 8;
    localparam int unsigned N_GRP        = 3;
    localparam int unsigned GRP_W        = 8;
    localparam int unsigned DIG_GRP      = 2;
    localparam int unsigned MEMCRC_BIT   = 0;
    localparam int unsigned MUX_SETTLE_CYC = 256;
    localparam logic [1:0]  CNT_ZERO     = 2'h0;
    localparam logic [1:0]  CNT_ONE      = 2'h1;
    localparam logic [7:0]  FLAGS_OK     = 8'hff;
    localparam logic        PIN_DIR_OUT  = 1'h1;
    localparam logic        PIN_SRC_FLT  = 1'h0;
    localparam logic        FMT_STATIC   = 1'h0;
    // checksum corruption patterns, selector value 0 leaves the checksum alone
    localparam logic [15:0] CRC_PAT1     = 16'h0001;
    localparam logic [15:0] CRC_PAT2     = 16'h0100;
    localparam logic [15:0] CRC_PAT3     = 16'h8000;
    localparam logic [15:0] CRC_PAT0     = 16'h0000;
    // positive channel codes that select a divided supply
    localparam logic [3:0]  CH_APWR      = 4'h8;
    localparam logic [3:0]  CH_DPWR      = 4'h9;
    localparam logic [3:0]  CH_AVDD      = 4'ha;
    localparam logic [3:0]  CH_IOVDD     = 4'hb;
    localparam logic [3:0]  CH_DVDD      = 4'hc;
    localparam logic [3:0]  RESP_NONE    = 4'h0;

    typedef enum logic [1:0] {
        MODE_ACTIVE  = 2'b00,
        MODE_STANDBY = 2'b01,
        MODE_PWRDN   = 2'b10
    } fpd_mode_t;

    typedef enum logic [2:0] {
        OTP_LOAD0 = 3'b000,
        OTP_LOAD1 = 3'b001,
        OTP_OK0   = 3'b010,
        OTP_OK1   = 3'b011,
        OTP_FAIL  = 3'b100
    } fpd_otp_t;

    // one detailed status group: monitor events, enables, injects, masks, clears
    typedef struct packed {
        logic [7:0] evt;
        logic [7:0] en;
        logic [7:0] diag;
        logic [7:0] mask;
        logic [7:0] clr;
    } fpd_group_t;

    typedef struct packed {
        logic       dir;
        logic       src;
        logic       fmt;
        logic       pol;
        logic       gp_data;
    } fpd_pin_cfg_t;
endpackage : fpd_pkg

// *** core/fpd_step_mem.sv ***
// two-bank step result store with registered read data
// assumes the owner flips the visible bank only when no readout is running
module fpd_step_mem #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned STEPS = 8,
    parameter int unsigned AW    = 3
) (
    // clocking
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    // fill side, always into the hidden bank
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             flip,
    // readout side, from the visible bank
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [2*STEPS];
    logic             vis_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vis_q <= 1'b0;
        end else if (ce && flip) begin
            vis_q <= ~vis_q;
        end
    end

    always_ff @(posedge clk) begin
        if (ce && wr_en) begin
            mem[{~vis_q, wr_addr}] <= wr_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (ce) begin
            rd_data <= mem[{vis_q, rd_addr}];
        end
    end
endmodule : fpd_step_mem

// *** core/fpd_top.sv ***
// fault pin, monitor diagnostics, status indicators and conversion counters
// assumes all inputs synchronous to CLK_SYS; event inputs are one-cycle pulses
module fpd_top #(
    parameter int unsigned N_MAIN       = 2,
    parameter int unsigned RES_W        = 24,
    parameter int unsigned AUX_W        = 16,
    parameter int unsigned AUX_STEPS    = 8,
    parameter int unsigned PWM_HALF_CYC = 200
) (
    // clocking
    input  wire logic                   CLK_SYS,
    input  wire logic                   RESETN,
    input  wire logic                   CE,
    // monitors and fault flags
    input  wire fpd_pkg::fpd_group_t [2:0] MON_GRP,
    input  wire logic [7:0]             SUM_EVT,
    input  wire logic [7:0]             SUM_CLR,
    input  wire logic [7:0]             PIN_MASK,
    output logic      [7:0]             SUM_FLAGS,
    output logic      [23:0]            DETAIL_FLAGS,
    // memory checksum
    input  wire logic [15:0]            CRC_CALC,
    input  wire logic [15:0]            CRC_STORED,
    input  wire logic [1:0]             CRC_PATTERN,
    // shared pin
    input  wire fpd_pkg::fpd_pin_cfg_t  PIN2_CFG,
    output logic                        PIN2_OUT,
    output logic                        PIN2_OE,
    // frame and command response
    input  wire logic                   FRAME_END,
    input  wire logic                   CMD_VALID,
    input  wire logic [3:0]             CMD_RESP,
    output logic      [3:0]             CMD_RESPONSE,
    // indicators
    input  wire logic                   LOCK_SET,
    input  wire logic                   LOCK_CLR,
    input  wire logic                   EXT_CLK_SEL,
    input  wire logic                   MODE_REQ_VALID,
    input  wire logic [1:0]             MODE_REQ,
    output logic                        LOCKED,
    output logic                        CLK_EXTERNAL,
    output logic      [1:0]             MODE,
    // otp loader
    input  wire logic                   OTP_ACK,
    input  wire logic                   OTP_ERR,
    output logic                        OTP_REQ,
    output logic                        OTP_BANK,
    output logic                        OTP_LOADED,
    // main converters
    input  wire logic [N_MAIN-1:0]      MAIN_EN,
    input  wire logic [N_MAIN-1:0]      MAIN_DONE,
    input  wire logic [N_MAIN*RES_W-1:0] MAIN_DATA,
    output logic      [N_MAIN*RES_W-1:0] MAIN_RESULT,
    output logic      [N_MAIN*2-1:0]    MAIN_COUNT,
    // auxiliary converter sequencer
    input  wire logic                   AUX_EN,
    input  wire logic                   AUX_SEQ_START,
    input  wire logic                   AUX_SEQ_DONE,
    input  wire logic                   AUX_STEP_WR,
    input  wire logic [2:0]             AUX_STEP_IDX,
    input  wire logic [AUX_W-1:0]       AUX_STEP_DATA,
    input  wire logic [3:0]             AUX_STEP_CH,
    input  wire logic                   AUX_RD_BUSY,
    input  wire logic [2:0]             AUX_RD_IDX,
    output logic      [AUX_W-1:0]       AUX_RD_DATA,
    output logic      [1:0]             AUX_COUNT,
    output logic                        AUX_RUNNING,
    output logic      [4:0]             SUPPLY_SEL
);
    localparam int unsigned PWM_W = $clog2(PWM_HALF_CYC + 1);

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    // ---- detailed flags and combined summary flags
    logic [2:0][7:0] det_q;
    logic [2:0][7:0] det_d;
    logic [2:0][7:0] fault_in;
    logic [7:0]      sum_q;
    logic [7:0]      sum_d;
    logic [15:0]     crc_pat;
    logic            crc_bad;
    fpd_pkg::fpd_otp_t otp_q;
    fpd_pkg::fpd_otp_t otp_d;

    assign crc_pat = (CRC_PATTERN == 2'h1) ? fpd_pkg::CRC_PAT1 :
                     (CRC_PATTERN == 2'h2) ? fpd_pkg::CRC_PAT2 :
                     (CRC_PATTERN == 2'h3) ? fpd_pkg::CRC_PAT3 : fpd_pkg::CRC_PAT0;
    assign crc_bad = (CRC_CALC ^ crc_pat) != CRC_STORED;

    genvar g;
    genvar b;
    generate
        for (g = 0; g < fpd_pkg::N_GRP; g++) begin : g_grp
            for (b = 0; b < fpd_pkg::GRP_W; b++) begin : g_bit
                logic extra;
                if (g == fpd_pkg::DIG_GRP && b == fpd_pkg::MEMCRC_BIT) begin : g_crc
                    // checksum runs always; a dead otp keeps it low
                    assign extra = crc_bad || (otp_q == fpd_pkg::OTP_FAIL);
                end else begin : g_plain
                    assign extra = 1'b0;
                end
                // injection only reaches an enabled monitor
                assign fault_in[g][b] = extra ||
                    (MON_GRP[g].en[b] && (MON_GRP[g].evt[b] || MON_GRP[g].diag[b]));
                // a fault in the clearing cycle wins over the clear
                assign det_d[g][b] = fault_in[g][b] ? 1'b0 :
                                     MON_GRP[g].clr[b] ? 1'b1 : det_q[g][b];
            end
        end
        for (g = 0; g < fpd_pkg::N_SUM; g++) begin : g_sum
            logic set_low;
            logic clr_ok;
            if (g < fpd_pkg::N_GRP) begin : g_comb
                assign set_low = |(~det_q[g] & ~MON_GRP[g].mask);
                assign clr_ok  = SUM_CLR[g] && (det_q[g] == fpd_pkg::FLAGS_OK);
            end else begin : g_direct
                assign set_low = SUM_EVT[g];
                assign clr_ok  = SUM_CLR[g];
            end
            assign sum_d[g] = set_low ? 1'b0 : clr_ok ? 1'b1 : sum_q[g];
        end
    endgenerate

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            det_q <= {3{fpd_pkg::FLAGS_OK}};
            sum_q <= fpd_pkg::FLAGS_OK;
        end else if (CE) begin
            det_q <= det_d;
            sum_q <= sum_d;
        end
    end
    assign SUM_FLAGS    = sum_q;
    assign DETAIL_FLAGS = det_q;

    // ---- fault pin
    logic             fault_act;
    logic             pwm_q;
    logic [PWM_W-1:0] pwm_cnt_q;
    logic             pwm_wrap;
    logic             inact_lvl;
    logic             pin_d;

    assign fault_act = |(~sum_q & ~PIN_MASK);
    assign pwm_wrap  = pwm_cnt_q == PWM_W'(PWM_HALF_CYC - 1);
    // the heartbeat replaces only the inactive level; active stays static
    assign inact_lvl = (PIN2_CFG.fmt == fpd_pkg::FMT_STATIC) ? ~PIN2_CFG.pol
                                                             : pwm_q;
    assign pin_d = (PIN2_CFG.src != fpd_pkg::PIN_SRC_FLT) ? PIN2_CFG.gp_data :
                   fault_act ? PIN2_CFG.pol : inact_lvl;

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            pwm_cnt_q <= '0;
            pwm_q     <= 1'b0;
        end else if (CE) begin
            pwm_cnt_q <= pwm_wrap ? '0 : pwm_cnt_q + PWM_W'(1);
            pwm_q     <= pwm_wrap ? ~pwm_q : pwm_q;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            PIN2_OUT <= 1'b1;
            PIN2_OE  <= 1'b0;
        end else if (CE) begin
            PIN2_OUT <= pin_d;
            PIN2_OE  <= PIN2_CFG.dir == fpd_pkg::PIN_DIR_OUT;
        end
    end

    // ---- command response and indicators
    logic [3:0] cmd_seen_q;
    logic       mode_ok;

    assign mode_ok = MODE_REQ_VALID && (MODE_REQ != 2'b11);

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            cmd_seen_q   <= fpd_pkg::RESP_NONE;
            CMD_RESPONSE <= fpd_pkg::RESP_NONE;
        end else if (CE) begin
            // the response out now describes the frame before
            if (FRAME_END) begin
                CMD_RESPONSE <= CMD_VALID ? CMD_RESP : cmd_seen_q;
                cmd_seen_q   <= fpd_pkg::RESP_NONE;
            end else if (CMD_VALID) begin
                cmd_seen_q <= CMD_RESP;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            LOCKED       <= 1'b0;
            CLK_EXTERNAL <= 1'b0;
            MODE         <= fpd_pkg::MODE_ACTIVE;
        end else if (CE) begin
            LOCKED       <= LOCK_SET ? 1'b1 : LOCK_CLR ? 1'b0 : LOCKED;
            CLK_EXTERNAL <= EXT_CLK_SEL;
            MODE         <= mode_ok ? MODE_REQ : MODE;
        end
    end

    // ---- otp bank loader
    always_comb begin
        otp_d = otp_q;
        unique case (otp_q)
            fpd_pkg::OTP_LOAD0: if (OTP_ERR) otp_d = fpd_pkg::OTP_LOAD1;
                                else if (OTP_ACK) otp_d = fpd_pkg::OTP_OK0;
            fpd_pkg::OTP_LOAD1: if (OTP_ERR) otp_d = fpd_pkg::OTP_FAIL;
                                else if (OTP_ACK) otp_d = fpd_pkg::OTP_OK1;
            fpd_pkg::OTP_OK0,
            fpd_pkg::OTP_OK1,
            fpd_pkg::OTP_FAIL:  otp_d = otp_q;
            default:            otp_d = fpd_pkg::OTP_FAIL;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            otp_q      <= fpd_pkg::OTP_LOAD0;
            OTP_REQ    <= 1'b0;
            OTP_BANK   <= 1'b0;
            OTP_LOADED <= 1'b0;
        end else if (CE) begin
            otp_q      <= otp_d;
            OTP_REQ    <= otp_d == fpd_pkg::OTP_LOAD0 || otp_d == fpd_pkg::OTP_LOAD1;
            OTP_BANK   <= otp_d != fpd_pkg::OTP_LOAD0 && otp_d != fpd_pkg::OTP_OK0;
            OTP_LOADED <= otp_d == fpd_pkg::OTP_OK0 || otp_d == fpd_pkg::OTP_OK1;
        end
    end

    // ---- main conversion counters, result and count leave together
    logic idle_mode;
    assign idle_mode = MODE != fpd_pkg::MODE_ACTIVE;

    genvar m;
    generate
        for (m = 0; m < N_MAIN; m++) begin : g_main
            always_ff @(posedge CLK_SYS) begin
                if (!RESETN) begin
                    MAIN_COUNT[2*m +: 2]      <= fpd_pkg::CNT_ZERO;
                    MAIN_RESULT[RES_W*m +: RES_W] <= '0;
                end else if (CE) begin
                    if (!MAIN_EN[m] || idle_mode) begin
                        MAIN_COUNT[2*m +: 2] <= fpd_pkg::CNT_ZERO;
                    end else if (MAIN_DONE[m]) begin
                        // two-bit add wraps 3 to 0 by itself
                        MAIN_COUNT[2*m +: 2] <= MAIN_COUNT[2*m +: 2] + fpd_pkg::CNT_ONE;
                        MAIN_RESULT[RES_W*m +: RES_W] <= MAIN_DATA[RES_W*m +: RES_W];
                    end
                end
            end
        end
    endgenerate

    // ---- auxiliary sequencer: counter, running flag, buffered results
    logic [1:0] aux_cnt_q;
    logic       pend_q;
    logic       flip;
    logic       aux_off;
    logic [4:0] sup_d;

    assign aux_off = !AUX_EN || idle_mode;
    // a completed sequence shows only once no readout is running
    assign flip = !aux_off && !AUX_RD_BUSY && (AUX_SEQ_DONE || pend_q);

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            aux_cnt_q   <= fpd_pkg::CNT_ZERO;
            AUX_COUNT   <= fpd_pkg::CNT_ZERO;
            pend_q      <= 1'b0;
            AUX_RUNNING <= 1'b0;
        end else if (CE) begin
            if (aux_off) begin
                aux_cnt_q <= fpd_pkg::CNT_ZERO;
                AUX_COUNT <= fpd_pkg::CNT_ZERO;
                pend_q    <= 1'b0;
            end else begin
                if (AUX_SEQ_DONE) begin
                    aux_cnt_q <= aux_cnt_q + fpd_pkg::CNT_ONE;
                end
                if (flip) begin
                    AUX_COUNT <= AUX_SEQ_DONE ? aux_cnt_q + fpd_pkg::CNT_ONE : aux_cnt_q;
                end
                pend_q <= AUX_RD_BUSY && (AUX_SEQ_DONE || pend_q);
            end
            AUX_RUNNING <= !aux_off && (AUX_SEQ_START || (AUX_RUNNING && !AUX_SEQ_DONE));
        end
    end

    // a second sequence ending before the readout finishes overwrites the held one
    fpd_step_mem #(
        .WIDTH (AUX_W),
        .STEPS (AUX_STEPS),
        .AW    (3)
    ) u_step_mem (
        .clk     (CLK_SYS),
        .rst_n   (RESETN),
        .ce      (CE),
        .wr_en   (AUX_STEP_WR),
        .wr_addr (AUX_STEP_IDX),
        .wr_data (AUX_STEP_DATA),
        .flip    (flip),
        .rd_addr (AUX_RD_IDX),
        .rd_data (AUX_RD_DATA)
    );

    assign sup_d = {AUX_STEP_CH == fpd_pkg::CH_DVDD,
                    AUX_STEP_CH == fpd_pkg::CH_IOVDD,
                    AUX_STEP_CH == fpd_pkg::CH_AVDD,
                    AUX_STEP_CH == fpd_pkg::CH_DPWR,
                    AUX_STEP_CH == fpd_pkg::CH_APWR};

    always_ff @(posedge CLK_SYS) begin
        if (!RESETN) begin
            SUPPLY_SEL <= '0;
        end else if (CE) begin
            SUPPLY_SEL <= aux_off ? '0 : sup_d;
        end
    end

    // ---- checks
    AST_PIN_FOLLOWS: assert property (
        (CE && PIN2_CFG.src == fpd_pkg::PIN_SRC_FLT && fault_act) |=> PIN2_OUT == $past(PIN2_CFG.pol))
        else $error("fault pin did not show active level");
    AST_PIN_OE: assert property (
        CE |=> PIN2_OE == ($past(PIN2_CFG.dir) == fpd_pkg::PIN_DIR_OUT))
        else $error("pin enable does not follow direction");
    AST_MASKED_QUIET: assert property (
        (CE && (sum_q | PIN_MASK) == fpd_pkg::FLAGS_OK && PIN2_CFG.fmt == fpd_pkg::FMT_STATIC
         && PIN2_CFG.src == fpd_pkg::PIN_SRC_FLT) |=> PIN2_OUT == ~$past(PIN2_CFG.pol))
        else $error("masked flags drove the fault pin");
    AST_COMB_SET: assert property (
        (CE && |(~det_q[0] & ~MON_GRP[0].mask)) |=> !sum_q[0])
        else $error("combined flag missed a detailed fault");
    AST_COMB_HOLD: assert property (
        (CE && !sum_q[2] && det_q[2] != fpd_pkg::FLAGS_OK) |=> !sum_q[2])
        else $error("combined flag cleared with detailed fault present");
    AST_INJECT: assert property (
        (CE && MON_GRP[0].en[2] && MON_GRP[0].diag[2]) |=>
            !det_q[0][2] ##1 (!sum_q[0] || $past(MON_GRP[0].mask[2])))
        else $error("diagnostic did not reach its flag");
    AST_OTP_DEAD: assert property (
        (CE && otp_q == fpd_pkg::OTP_FAIL) |=> !det_q[fpd_pkg::DIG_GRP][fpd_pkg::MEMCRC_BIT])
        else $error("dead otp did not flag checksum");
    AST_CONV_CLR: assert property (
        (CE && idle_mode) |=> MAIN_COUNT == '0)
        else $error("conversion counter not cleared");
    AST_CONV_WRAP: assert property (
        (CE && MAIN_EN[0] && !idle_mode && MAIN_DONE[0]) |=>
            MAIN_COUNT[1:0] == $past(MAIN_COUNT[1:0]) + fpd_pkg::CNT_ONE)
        else $error("conversion counter did not step");
    AST_HOLD_READ: assert property (
        (CE && AUX_RD_BUSY) |=> $stable(AUX_COUNT) || !$past(AUX_EN) || $past(idle_mode))
        else $error("sequence count changed during readout");
endmodule : fpd_top

// *** tb/fpd_host_model.sv ***
// otp loader stand-in on the far side of the loader handshake
// assumes the bench picks how many bank reads fail before the next reset
module fpd_host_model (
    // clocking
    input  wire logic       clk,
    input  wire logic       rst_n,
    // loader handshake
    input  wire logic       otp_req,
    input  wire logic [1:0] n_err,
    output logic            otp_ack,
    output logic            otp_err
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] k_q;
    logic [1:0] used_q;
    // answer comes a few cycles late, never in the request cycle
    always @(posedge clk) begin
        otp_ack <= 1'b0;
        otp_err <= 1'b0;
        if (!rst_n) begin
            k_q    <= 2'h0;
            used_q <= 2'h0;
        end else if (otp_req && !otp_ack && !otp_err) begin
            k_q <= k_q + 2'h1;
            if (k_q == 2'h3) begin
                if (used_q < n_err) begin
                    otp_err <= 1'b1;
                    used_q  <= used_q + 2'h1;
                end else begin
                    otp_ack <= 1'b1;
                end
            end
        end
    end
endmodule : fpd_host_model

// *** tb/fpd_top_tb.sv ***
// self-checking bench for the fault pin, diagnostics, indicators and counters
// assumes fpd_top with a short pwm half period and the loader model beside it
module fpd_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rstn, ce, fr_end, cmd_vld, lk_set, lk_clr, ext_clk, mode_vld;
    logic aux_en, aux_go, aux_done, aux_wr, aux_busy, pin_out, pin_oe, locked;
    logic clk_ext, otp_ack, otp_err, otp_req, otp_bank, otp_ok, running;
    fpd_pkg::fpd_group_t [2:0] mon;
    fpd_pkg::fpd_pin_cfg_t     cfg;
    logic [7:0]  sum_evt, sum_clr, pin_mask, sum;
    logic [23:0] det;
    logic [15:0] crc_a, crc_b, aux_d, aux_rd, d1;
    logic [1:0]  crc_pat, mode_req, mode, aux_cnt, main_en, main_done, n_err;
    logic [3:0]  cmd_in, cmd_out, aux_ch, main_cnt;
    logic [2:0]  aux_idx, rd_idx;
    logic [47:0] main_d, main_r;
    logic [4:0]  supply;
    integer      seed, err_total, n_checks, k, n;
    fpd_top #(.PWM_HALF_CYC(4)) DUT (.CLK_SYS(clk), .RESETN(rstn), .CE(ce), .MON_GRP(mon),
        .SUM_EVT(sum_evt), .SUM_CLR(sum_clr), .PIN_MASK(pin_mask), .SUM_FLAGS(sum),
        .DETAIL_FLAGS(det), .CRC_CALC(crc_a), .CRC_STORED(crc_b), .CRC_PATTERN(crc_pat),
        .PIN2_CFG(cfg), .PIN2_OUT(pin_out), .PIN2_OE(pin_oe), .FRAME_END(fr_end),
        .CMD_VALID(cmd_vld), .CMD_RESP(cmd_in), .CMD_RESPONSE(cmd_out), .LOCK_SET(lk_set),
        .LOCK_CLR(lk_clr), .EXT_CLK_SEL(ext_clk), .MODE_REQ_VALID(mode_vld),
        .MODE_REQ(mode_req), .LOCKED(locked), .CLK_EXTERNAL(clk_ext), .MODE(mode),
        .OTP_ACK(otp_ack), .OTP_ERR(otp_err), .OTP_REQ(otp_req), .OTP_BANK(otp_bank),
        .OTP_LOADED(otp_ok), .MAIN_EN(main_en), .MAIN_DONE(main_done), .MAIN_DATA(main_d),
        .MAIN_RESULT(main_r), .MAIN_COUNT(main_cnt), .AUX_EN(aux_en), .AUX_SEQ_START(aux_go),
        .AUX_SEQ_DONE(aux_done), .AUX_STEP_WR(aux_wr), .AUX_STEP_IDX(aux_idx),
        .AUX_STEP_DATA(aux_d), .AUX_STEP_CH(aux_ch), .AUX_RD_BUSY(aux_busy),
        .AUX_RD_IDX(rd_idx), .AUX_RD_DATA(aux_rd), .AUX_COUNT(aux_cnt),
        .AUX_RUNNING(running), .SUPPLY_SEL(supply));
    fpd_host_model HOST (.clk(clk), .rst_n(rstn), .otp_req(otp_req), .n_err(n_err),
        .otp_ack(otp_ack), .otp_err(otp_err));
    function automatic logic pin_lvl(input logic active, input logic pol);
        return active ? pol : ~pol;
    endfunction : pin_lvl
    task automatic cyc(input integer c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic do_reset(input logic [1:0] e);
        n_err = e;
        rstn  = 1'b0;
        cyc(16);
        rstn = 1'b1;
        cyc(16);
    endtask : do_reset
    task automatic tally_and_finish;
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #(25 * 20000);
        err_total = err_total + 1;
        tally_and_finish();
    end
    initial begin
        {ce, fr_end, cmd_vld, lk_set, lk_clr, ext_clk, mode_vld} = '0;
        {aux_en, aux_go, aux_done, aux_wr, aux_busy, sum_evt, sum_clr, pin_mask} = '0;
        {mon, crc_pat, mode_req, main_en, main_done, cmd_in, aux_ch, aux_idx, rd_idx} = '0;
        {main_d, aux_d} = '0;
        seed = 86;
        err_total = 0;
        n_checks = 0;
        ce = 1'b1;
        crc_a = $random(seed);
        crc_b = crc_a;
        cfg = '{dir: 1'b1, src: 1'b0, fmt: 1'b0, pol: 1'b0, gp_data: 1'b0};
        mon[0].en = 8'hff;
        do_reset(2'h0);
        chk({otp_ok, otp_bank, pin_oe, pin_out}, {3'h5, pin_lvl(1'b0, 1'b0)});
        // diagnostic inject on one monitor only, bit 2 of group 0, keeps the checksum tests apart
        mon[0].diag = 8'h04;
        cyc(4);
        chk({det[2], sum[0], pin_out}, {2'h0, pin_lvl(1'b1, 1'b0)});
        pin_mask = 8'h01;
        cyc(2);
        chk(pin_out, pin_lvl(1'b0, 1'b0));
        cfg.pol = 1'b1;
        pin_mask = 8'h00;
        cyc(2);
        chk(pin_out, pin_lvl(1'b1, 1'b1));
        {mon[0].en, mon[0].diag, sum_clr} = {16'h0000, 8'h01};
        cyc(1);
        sum_clr = 8'h00;
        cyc(2);
        chk(sum[0], 1'b0);
        mon[0].clr = 8'h04;
        cyc(1);
        mon[0].clr = 8'h00;
        sum_clr = 8'h01;
        cyc(1);
        sum_clr = 8'h00;
        cyc(3);
        chk({det[2], sum[0], pin_out}, 3'h6);
        cfg.pol = 1'b0;
        cfg.fmt = 1'b1;
        n = 0;
        for (k = 0; k < 16; k++) begin
            cyc(1);
            n = n + pin_out;
        end
        chk(n, 8);
        cfg = '{dir: 1'b1, src: 1'b1, fmt: 1'b0, pol: 1'b0, gp_data: 1'b0};
        cyc(2);
        chk({pin_oe, pin_out}, 2'h2);
        cfg.dir = 1'b0;
        cyc(2);
        chk(pin_oe, 1'b0);
        for (k = 1; k < 4; k++) begin
            crc_pat = k;
            cyc(4);
            chk(det[16], 1'b0);
            crc_pat = 2'h0;
            mon[2].clr = 8'h01;
            cyc(1);
            mon[2].clr = 8'h00;
            cyc(2);
            chk(det[16], 1'b1);
        end
        for (k = 0; k < 4; k++) begin
            cmd_in = $random(seed);
            cmd_vld = 1'b1;
            cyc(1);
            {cmd_vld, fr_end} = 2'h1;
            cyc(1);
            fr_end = 1'b0;
            cyc(1);
            chk(cmd_out, cmd_in);
        end
        {lk_set, ext_clk} = 2'h3;
        cyc(1);
        lk_set = 1'b0;
        cyc(1);
        chk({locked, clk_ext}, 2'h3);
        // clock enable low must freeze the lock bit and the summary flags
        {ce, lk_clr, sum_evt} = {2'h1, 8'h80};
        cyc(2);
        chk({locked, sum[7]}, 2'h3);
        ce = 1'b1;
        cyc(1);
        {lk_clr, sum_evt} = 9'h0;
        cyc(1);
        chk({locked, sum[7]}, 2'h0);
        main_en = 2'h3;
        n = 5 + ($random(seed) & 3);
        for (k = 0; k < n; k++) begin
            main_d = {$random(seed), $random(seed)};
            main_done = 2'h1;
            cyc(1);
            main_done = 2'h0;
            cyc(1);
        end
        chk({main_cnt[1:0], main_r[23:0]}, {n[1:0], main_d[23:0]});
        mode_req = fpd_pkg::MODE_STANDBY;
        mode_vld = 1'b1;
        cyc(1);
        mode_vld = 1'b0;
        cyc(1);
        chk({mode, main_cnt[1:0]}, {fpd_pkg::MODE_STANDBY, 2'h0});
        {mode_req, mode_vld, aux_en} = 4'h3;
        cyc(1);
        mode_vld = 1'b0;
        for (k = 0; k < 5; k++) begin
            aux_ch = fpd_pkg::CH_APWR + k;
            cyc(2);
            chk(supply, 5'h01 << k);
        end
        {aux_en, aux_go} = 2'h3;
        cyc(1);
        aux_go = 1'b0;
        chk(running, 1'b1);
        d1 = $random(seed);
        {aux_wr, aux_idx, aux_d, rd_idx} = {1'b1, 3'h3, d1, 3'h3};
        cyc(1);
        {aux_wr, aux_done} = 2'h1;
        cyc(1);
        aux_done = 1'b0;
        cyc(1);
        chk({running, aux_cnt, aux_rd}, {3'h1, d1});
        {aux_wr, aux_d, aux_busy} = {1'b1, ~d1, 1'b1};
        cyc(1);
        {aux_wr, aux_done} = 2'h1;
        cyc(1);
        aux_done = 1'b0;
        cyc(2);
        chk({aux_cnt, aux_rd}, {2'h1, d1});
        aux_busy = 1'b0;
        cyc(3);
        chk({aux_cnt, aux_rd}, {2'h2, ~d1});
        aux_en = 1'b0;
        cyc(2);
        chk(aux_cnt, 2'h0);
        do_reset(2'h1);
        chk({otp_ok, otp_bank, det[16]}, 3'h7);
        do_reset(2'h2);
        chk({otp_ok, otp_bank, det[16]}, 3'h2);
        tally_and_finish();
    end
endmodule : fpd_top_tb
